// ===== eos_pkg.sv
// Constants, register map and types of the E1 receive overhead status bank
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package eos_pkg;

   // ------------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------------
   localparam logic [7:0] IDX_NON_ALIGN  = 8'h13;
   localparam logic [7:0] IDX_MF_ALIGN   = 8'h14;
   localparam logic [7:0] IDX_PHASE_HIGH = 8'h15;
   localparam logic [7:0] IDX_PHASE_LOW  = 8'h16;
   localparam logic [7:0] IDX_JITTER     = 8'h17;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;

   // ------------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------------
   localparam int PH_SLIP_BIT   = 7;
   localparam int PH_DIR_BIT    = 6;
   localparam int PH_AUX_BIT    = 5;
   localparam int PH_TWO_BAD_BIT = 4;
   localparam int PH_CNT_HI_W   = 4;
   localparam int PH_CNT_W      = 12;
   localparam int NFAS_ALARM_BIT = 5;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam logic [11:0] PHASE_RESET = 12'h000;

   // Interrupt status / mask layout
   localparam int IRQ_W        = 5;
   localparam int IRQ_SLIP     = 0;
   localparam int IRQ_AUX      = 1;
   localparam int IRQ_TWO_BAD  = 2;
   localparam int IRQ_ALARM    = 3;
   localparam int IRQ_JA_LIMIT = 4;
   localparam logic [4:0] IRQ_RESET = 5'h00;

   // ------------------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------------------
   localparam int AUX_MIN_BITS = 512;
   localparam int AUX_MAX_ERR  = 1;
   localparam int JA_MARGIN    = 4;

   // Auxiliary pattern detector states
   typedef enum logic [1:0] {
      EOS_AUX_HUNT   = 2'b01,
      EOS_AUX_LOCKED = 2'b10
   } eos_aux_state_t;

endpackage : eos_pkg

// ===== eos_byte_latch.sv
// Capture register loaded by a one-cycle strobe from the receive framer
module eos_byte_latch #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Capture strobe and data
   input  wire logic         load,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // Holds the last captured overhead word until the next one arrives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (load) begin
         q <= d;
      end
   end
endmodule // eos_byte_latch

// ===== eos_aux_detect.sv
// Auxiliary 1010 pattern detector working on fixed windows of received bits
module eos_aux_detect #(
   parameter int WIN     = eos_pkg::AUX_MIN_BITS,
   parameter int MAX_ERR = eos_pkg::AUX_MAX_ERR
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Received line bits
   input  wire logic bit_valid,
   input  wire logic line_bit,
   // Detection flag
   output logic      detect
);
   localparam int CW = $clog2(WIN + 1);

   eos_pkg::eos_aux_state_t state;
   logic          prev_bit;
   logic [CW-1:0] bit_cnt;
   logic [CW-1:0] err_cnt;
   logic          miss;
   logic          win_end;

   // A repeat of the previous bit breaks the alternation
   assign miss    = (line_bit == prev_bit);
   assign win_end = bit_valid && (bit_cnt == CW'(WIN - 1));

   // Window counters; a 1e-3 error rate gives under one error per window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_bit <= 1'b0;
         bit_cnt  <= '0;
         err_cnt  <= '0;
      end else if (bit_valid) begin
         prev_bit <= line_bit;
         bit_cnt  <= win_end ? '0 : bit_cnt + 1'b1;
         err_cnt  <= win_end ? '0 : err_cnt + CW'(miss);
      end
   end

   // Verdict at each window end: the flag follows a whole window of pattern.
   // One flipped bit breaks the alternation on both sides, so each tolerated error costs two misses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= eos_pkg::EOS_AUX_HUNT;
      end else if (win_end) begin
         case (state)
            eos_pkg::EOS_AUX_HUNT,
            eos_pkg::EOS_AUX_LOCKED: begin
               state <= ((err_cnt + CW'(miss)) <= CW'(2 * MAX_ERR)) ? eos_pkg::EOS_AUX_LOCKED
                                                                 : eos_pkg::EOS_AUX_HUNT;
            end
            default: state <= eos_pkg::EOS_AUX_HUNT;
         endcase
      end
   end

   assign detect = (state == eos_pkg::EOS_AUX_LOCKED);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_aux_clean_window: assert property (win_end && err_cnt == '0 && !miss |=> detect)
      else $error("aux pattern not flagged after clean window");
   a_aux_bad_window: assert property (win_end && err_cnt > CW'(2 * MAX_ERR) |=> !detect)
      else $error("aux pattern flagged after errored window");
endmodule // eos_aux_detect

// ===== eos_rx_status.sv
// E1 receive overhead status bank with AHB-Lite register slave and interrupt
module eos_rx_status #(
   parameter int JA_DEPTH = 16,
   parameter int JA_LW    = $clog2(JA_DEPTH + 1)
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic      [31:0]      hrdata,
   output logic                  hresp,
   // Overhead words from the receive framer
   input  wire logic             nfas_valid,
   input  wire logic [7:0]       nfas_byte,
   input  wire logic             mf_valid,
   input  wire logic [7:0]       mf_byte,
   input  wire logic             fas_valid,
   input  wire logic             fas_errored,
   // Elastic buffer slips
   input  wire logic             slip_pulse,
   input  wire logic             slip_repeat,
   // Received line bits
   input  wire logic             line_valid,
   input  wire logic             line_bit,
   // Phase measurement
   input  wire logic             eighth_tick,
   input  wire logic             bp_frame_pulse,
   input  wire logic             rx_frame_pulse,
   // Jitter attenuator
   input  wire logic             ja_clk_slow_adj,
   input  wire logic             ja_clk_fast_adj,
   input  wire logic [JA_LW-1:0] ja_fifo_level,
   // Interrupt
   output logic                  irq
);

   // ------------------------------------------------------------------------
   // Overhead word capture
   // ------------------------------------------------------------------------
   logic [7:0] nfas_q;
   logic [7:0] mf_q;
   logic       rx_intl_bit_nfas;
   logic       rx_nfas_marker_bit;
   logic       rx_remote_alarm_bit;
   logic [4:0] rx_national_spare_bits;
   logic [3:0] rx_mf_align_pattern;
   logic       rx_spare_one;
   logic       rx_remote_mf_loss;
   logic       rx_spare_two;
   logic       rx_spare_three;

   // The received NFAS byte keeps line order: bit 1 on the wire lands in bit 7
   eos_byte_latch #(.W(8)) u_nfas (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (nfas_valid),
      .d     (nfas_byte),
      .q     (nfas_q)
   );

   // Time slot 16 of frame zero, same ordering
   eos_byte_latch #(.W(8)) u_mf (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (mf_valid),
      .d     (mf_byte),
      .q     (mf_q)
   );

   // Field split of the two captured words
   assign rx_intl_bit_nfas       = nfas_q[7];
   assign rx_nfas_marker_bit     = nfas_q[6];
   assign rx_remote_alarm_bit    = nfas_q[5];
   assign rx_national_spare_bits = nfas_q[4:0];
   assign rx_mf_align_pattern    = mf_q[7:4];
   assign rx_spare_one           = mf_q[3];
   assign rx_remote_mf_loss      = mf_q[2];
   assign rx_spare_two           = mf_q[1];
   assign rx_spare_three         = mf_q[0];

   // ------------------------------------------------------------------------
   // Slip, alignment word errors and auxiliary pattern
   // ------------------------------------------------------------------------
   logic slip_toggle;
   logic slip_direction;
   logic last_fas_bad;
   logic two_bad_align_words;
   logic aux_pattern_detect;

   // A slip is reported as a change of level so a single slip between reads is not lost; two slips cancel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slip_toggle    <= 1'b0;
         slip_direction <= 1'b0;
      end else if (slip_pulse) begin
         slip_toggle    <= ~slip_toggle;
         slip_direction <= slip_repeat;
      end
   end

   // Two consecutive errored frame alignment words
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_fas_bad        <= 1'b0;
         two_bad_align_words <= 1'b0;
      end else if (fas_valid) begin
         last_fas_bad        <= fas_errored;
         two_bad_align_words <= fas_errored && last_fas_bad;
      end
   end

   // Pattern detector on the raw received bits
   eos_aux_detect #(
      .WIN     (eos_pkg::AUX_MIN_BITS),
      .MAX_ERR (eos_pkg::AUX_MAX_ERR)
   ) u_aux (
      .clk       (clk),
      .rst_n     (rst_n),
      .bit_valid (line_valid),
      .line_bit  (line_bit),
      .detect    (aux_pattern_detect)
   );

   // ------------------------------------------------------------------------
   // Eighth-bit phase count
   // ------------------------------------------------------------------------
   logic [eos_pkg::PH_CNT_W-1:0] eighth_cnt;
   logic [eos_pkg::PH_CNT_W-1:0] eighth_bit_phase_count;

   // Runs from the backplane frame pulse; a tick at the rate of eight per bit
   // bounds the sampling error near one eighth of a bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eighth_cnt <= eos_pkg::PHASE_RESET;
      end else if (bp_frame_pulse) begin
         eighth_cnt <= eos_pkg::PHASE_RESET;
      end else if (eighth_tick) begin
         eighth_cnt <= eighth_cnt + 1'b1;
      end
   end

   // Snapshot at the receive frame pulse so software reads a stable value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eighth_bit_phase_count <= eos_pkg::PHASE_RESET;
      end else if (rx_frame_pulse) begin
         eighth_bit_phase_count <= eighth_cnt;
      end
   end

   // ------------------------------------------------------------------------
   // Jitter attenuator flags
   // ------------------------------------------------------------------------
   logic [7:0] ja_status;
   logic       dejitter_clock_slow;
   logic       dejitter_clock_fast;
   logic       dejitter_fifo_empty;
   logic       dejitter_fifo_four_full;
   logic       dejitter_fifo_half;
   logic       dejitter_fifo_four_empty;
   logic       dejitter_fifo_full;

   // Registered so a read never sees a half-settled level compare
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ja_status <= eos_pkg::BYTE_RESET;
      end else begin
         ja_status <= {ja_clk_slow_adj,
                       ja_clk_fast_adj,
                       ja_fifo_level == '0,
                       ja_fifo_level >= JA_LW'(eos_pkg::JA_MARGIN),
                       ja_fifo_level >= JA_LW'(JA_DEPTH / 2),
                       ja_fifo_level >= JA_LW'(JA_DEPTH - eos_pkg::JA_MARGIN),
                       ja_fifo_level == JA_LW'(JA_DEPTH),
                       1'b0};
      end
   end

   assign dejitter_clock_slow      = ja_status[7];
   assign dejitter_clock_fast      = ja_status[6];
   assign dejitter_fifo_empty      = ja_status[5];
   assign dejitter_fifo_four_full  = ja_status[4];
   assign dejitter_fifo_half       = ja_status[3];
   assign dejitter_fifo_four_empty = ja_status[2];
   assign dejitter_fifo_full       = ja_status[1];

   // ------------------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------------------
   logic [eos_pkg::IRQ_W-1:0] irq_status;
   logic [eos_pkg::IRQ_W-1:0] irq_mask;
   logic [eos_pkg::IRQ_W-1:0] irq_event;
   logic [eos_pkg::IRQ_W-1:0] irq_clear;
   logic                      aux_prev;
   logic                      two_bad_prev;
   logic                      ja_limit_prev;
   logic                      ja_limit;

   assign ja_limit = dejitter_fifo_full || dejitter_fifo_empty;

   // Previous levels for edge events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_prev      <= 1'b0;
         two_bad_prev  <= 1'b0;
         ja_limit_prev <= 1'b0;
      end else begin
         aux_prev      <= aux_pattern_detect;
         two_bad_prev  <= two_bad_align_words;
         ja_limit_prev <= ja_limit;
      end
   end

   // Events: slip, pattern found, two bad words, alarm bit change, FIFO limit
   always_comb begin
      irq_event                        = '0;
      irq_event[eos_pkg::IRQ_SLIP]     = slip_pulse;
      irq_event[eos_pkg::IRQ_AUX]      = aux_pattern_detect && !aux_prev;
      irq_event[eos_pkg::IRQ_TWO_BAD]  = two_bad_align_words && !two_bad_prev;
      irq_event[eos_pkg::IRQ_ALARM]    = nfas_valid && (nfas_byte[eos_pkg::NFAS_ALARM_BIT] != rx_remote_alarm_bit);
      irq_event[eos_pkg::IRQ_JA_LIMIT] = ja_limit && !ja_limit_prev;
   end

   // ------------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------------
   logic       addr_ok;
   logic       acc_start;
   logic [7:0] acc_idx;
   logic       wr_pend;
   logic [7:0] wr_idx;
   logic [7:0] rd_byte;

   // Zero wait states: every transfer finishes in its first data-phase cycle
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
   assign acc_start = hsel && htrans[1] && hready;
   assign acc_idx   = haddr[9:2];

   // Write address held into the data phase, where hwdata stands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_idx  <= 8'h00;
      end else begin
         wr_pend <= acc_start && hwrite && addr_ok;
         wr_idx  <= acc_idx;
      end
   end

   // Only the interrupt words accept writes; status words ignore them
   assign irq_clear = (wr_pend && wr_idx == eos_pkg::IDX_IRQ_STATUS) ? hwdata[eos_pkg::IRQ_W-1:0] : '0;

   // Write-one-to-clear; a new event in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= eos_pkg::IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= eos_pkg::IRQ_RESET;
      end else if (wr_pend && wr_idx == eos_pkg::IDX_IRQ_MASK) begin
         irq_mask <= hwdata[eos_pkg::IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // Read decode; reads change no state
   always_comb begin
      case (acc_idx)
         eos_pkg::IDX_NON_ALIGN:  rd_byte = {rx_intl_bit_nfas, rx_nfas_marker_bit, rx_remote_alarm_bit,
                                             rx_national_spare_bits};
         eos_pkg::IDX_MF_ALIGN:   rd_byte = {rx_mf_align_pattern, rx_spare_one, rx_remote_mf_loss,
                                             rx_spare_two, rx_spare_three};
         eos_pkg::IDX_PHASE_HIGH: rd_byte = {slip_toggle, slip_direction, aux_pattern_detect,
                                             two_bad_align_words,
                                             eighth_bit_phase_count[eos_pkg::PH_CNT_W-1:8]};
         eos_pkg::IDX_PHASE_LOW:  rd_byte = eighth_bit_phase_count[7:0];
         eos_pkg::IDX_JITTER:     rd_byte = ja_status;
         eos_pkg::IDX_IRQ_STATUS: rd_byte = {3'h0, irq_status};
         eos_pkg::IDX_IRQ_MASK:   rd_byte = {3'h0, irq_mask};
         default:                 rd_byte = 8'h00;
      endcase
   end

   // Read data sampled in the address phase, presented in the data phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else if (acc_start && !hwrite) begin
         hrdata <= addr_ok ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_read_addr(logic [7:0] idx);
      acc_start && !hwrite && addr_ok && acc_idx == idx;
   endsequence

   sequence s_write_data(logic [7:0] idx);
      wr_pend && wr_idx == idx;
   endsequence

   a_nfas_read_back: assert property (nfas_valid ##1 s_read_addr(eos_pkg::IDX_NON_ALIGN) |=>
                                      hrdata[7:0] == $past(nfas_byte, 2))
      else $error("NFAS word not read back as captured");
   a_mf_read_back: assert property (mf_valid ##1 s_read_addr(eos_pkg::IDX_MF_ALIGN) |=>
                                    hrdata[7:0] == $past(mf_byte, 2))
      else $error("TS16 word not read back as captured");
   a_slip_toggle_flip: assert property (slip_pulse |=> slip_toggle != $past(slip_toggle))
      else $error("slip toggle did not change on slip");
   a_slip_toggle_hold: assert property (!slip_pulse |=> $stable(slip_toggle))
      else $error("slip toggle changed without slip");
   a_slip_dir_track: assert property (slip_pulse |=> slip_direction == $past(slip_repeat))
      else $error("slip direction not updated");
   a_two_bad_set: assert property (fas_valid && fas_errored ##1 !fas_valid ##1
                                   fas_valid && fas_errored |=> two_bad_align_words)
      else $error("two errored words not flagged");
   a_two_bad_clear: assert property (fas_valid && !fas_errored |=> !two_bad_align_words)
      else $error("flag set with a correct word");
   a_phase_latch: assert property (bp_frame_pulse ##1 (!bp_frame_pulse && !eighth_tick)[*2] ##0
                                   rx_frame_pulse |=> eighth_bit_phase_count == 12'h000)
      else $error("phase count wrong with no ticks");
   a_ja_full_flag: assert property (ja_fifo_level == JA_LW'(JA_DEPTH) |=> dejitter_fifo_full &&
                                    dejitter_fifo_four_empty && dejitter_fifo_half)
      else $error("full FIFO flags wrong");
   a_ja_empty_flag: assert property (ja_fifo_level == '0 |=> dejitter_fifo_empty &&
                                     !dejitter_fifo_four_full && !dejitter_fifo_half)
      else $error("empty FIFO flags wrong");
   a_ja_four_full: assert property (ja_fifo_level == JA_LW'(eos_pkg::JA_MARGIN) |=>
                                    dejitter_fifo_four_full)
      else $error("four full flag missing");
   a_ja_clock_adj: assert property (ja_clk_slow_adj && !ja_clk_fast_adj |=>
                                    dejitter_clock_slow && !dejitter_clock_fast)
      else $error("clock adjust flags wrong");
   a_ja_bit_zero: assert property (s_read_addr(eos_pkg::IDX_JITTER) |=> hrdata[0] == 1'b0)
      else $error("unused jitter bit not zero");
   a_ro_write_ignored: assert property (s_write_data(eos_pkg::IDX_NON_ALIGN) && !nfas_valid |=>
                                        $stable(nfas_q))
      else $error("write altered read-only word");
   a_irq_set_wins: assert property (slip_pulse && irq_clear[eos_pkg::IRQ_SLIP] |=>
                                    irq_status[eos_pkg::IRQ_SLIP])
      else $error("event lost against clear");

endmodule // eos_rx_status

// ===== eos_line_model.sv
// Behavioural far-end line terminal sending one burst of auxiliary pattern
module eos_line_model (
   // Clock and burst control
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [9:0] err_at,
   // Line bits towards the block and burst busy flag
   output logic            line_valid,
   output logic            line_bit,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int n;
   initial {line_valid, line_bit, busy, n} = '0;
   // 512 alternating bits from a one, one bit flipped; idle line toggles so no stale level lingers
   always @(posedge clk) begin
      if (start && !busy) begin
         busy <= 1'b1;
         n <= 0;
      end else if (busy) begin
         line_valid <= 1'b1;
         line_bit <= (n % 2 == 0) ^ (n == err_at);
         n <= n + 1;
         busy <= (n != 511);
      end else begin
         line_valid <= 1'b0;
         line_bit <= !line_bit;
      end
   end
endmodule // eos_line_model

// ===== test_e1_receive_overhead_status.sv
// Self-checking bench of the receive overhead status bank
module test_e1_receive_overhead_status;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_n = 0, hwrite = 0, dph = 0, go = 0, fe = 0, sr = 0, js = 0, jf = 0;
   logic        hreadyout, hresp, irq, lv, lb, busy;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q[$];
   logic [6:0]  stb = 0;
   logic [7:0]  nb = 0, mb = 0;
   logic [4:0]  lvl = 0;
   logic [9:0]  ea = 0;
   int          fail_count = 0, checks = 0, seed = 78523, n;
   always #50 clk = ~clk;
   eos_rx_status u_eos_rx_status (.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .nfas_valid(stb[0]), .nfas_byte(nb), .mf_valid(stb[1]),
      .mf_byte(mb), .fas_valid(stb[2]), .fas_errored(fe), .slip_pulse(stb[3]), .slip_repeat(sr), .line_valid(lv),
      .line_bit(lb), .eighth_tick(stb[4]), .bp_frame_pulse(stb[5]), .rx_frame_pulse(stb[6]),
      .ja_clk_slow_adj(js), .ja_clk_fast_adj(jf), .ja_fifo_level(lvl), .irq);
   eos_line_model u_eos_line_model (.clk, .start(go), .err_at(ea), .line_valid(lv), .line_bit(lb), .busy);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Single AHB transfer; request held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      dph <= !w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      dph <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask
   task automatic pulse(input int b);
      stb[b] <= 1'b1;
      @(posedge clk);
      stb[b] <= 1'b0;
      @(posedge clk);
   endtask
   // Oldest noted read value against the data phase that ends at this edge
   always @(posedge clk) if (dph && hreadyout) begin
      check(hrdata, q.pop_front());
      check({31'h0, hresp}, 32'h0);
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (n = 0; n <= 16; n++) begin
         lvl <= n[4:0];
         {js, jf} <= 2'($random(seed));
         repeat (2) @(posedge clk);
         rd(eos_pkg::IDX_JITTER, {24'h0, js, jf, n == 0, n >= 4, n >= 8, n >= 12, n == 16, 1'b0});
      end
      nb <= 8'($random(seed));
      mb <= 8'($random(seed));
      stb[0] <= 1'b1;
      @(posedge clk);
      stb[0] <= 1'b0;
      // Read right behind the capture strobe, the closest spacing allowed
      rd(eos_pkg::IDX_NON_ALIGN, {24'h0, nb});
      stb[1] <= 1'b1;
      @(posedge clk);
      stb[1] <= 1'b0;
      rd(eos_pkg::IDX_MF_ALIGN, {24'h0, mb});
      bus(1'b1, eos_pkg::IDX_NON_ALIGN, ~{24'h0, nb});
      rd(eos_pkg::IDX_NON_ALIGN, {24'h0, nb});
      sr <= 1'b1;
      pulse(3);
      rd(eos_pkg::IDX_PHASE_HIGH, 32'hc0);
      sr <= 1'b0;
      pulse(3);
      rd(eos_pkg::IDX_PHASE_HIGH, 32'h00);
      fe <= 1'b1;
      pulse(2);
      pulse(2);
      rd(eos_pkg::IDX_PHASE_HIGH, 32'h10);
      fe <= 1'b0;
      pulse(2);
      rd(eos_pkg::IDX_PHASE_HIGH, 32'h00);
      $display("capture, slip and alignment tests done");
      // A tick before the backplane pulse must be cleared away
      pulse(4);
      pulse(5);
      pulse(6);
      rd(eos_pkg::IDX_PHASE_LOW, 32'h0);
      n = 256 + {$random(seed)} % 200;
      pulse(5);
      repeat (n) pulse(4);
      pulse(6);
      rd(eos_pkg::IDX_PHASE_LOW, 32'(n & 255));
      // One flipped bit inside the window must still be tolerated
      ea <= 10'(1 + {$random(seed)} % 510);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
      while (busy) @(posedge clk);
      repeat (3) @(posedge clk);
      rd(eos_pkg::IDX_PHASE_HIGH, 32'h20 | 32'(n >> 8));
      bus(1'b1, eos_pkg::IDX_IRQ_MASK, 32'h0);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, eos_pkg::IDX_IRQ_MASK, 32'h2);
      @(posedge clk);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, eos_pkg::IDX_IRQ_STATUS, 32'h1f);
      @(posedge clk);
      check({31'h0, irq}, 32'h0);
      rd(eos_pkg::IDX_IRQ_STATUS, 32'h0);
      rd(8'h30, 32'h0);
      $display("phase, aux and interrupt tests done");
      stop_test();
   end
   // Watchdog well beyond the fewer than two thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test();
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
endmodule // test_e1_receive_overhead_status
